//--- src/tvms_top.sv
// round-robin voltage and temperature monitoring sequencer with apb registers
// How it works
// RULE1 - local sensor result lands at index 1Fh
// RULE2 - temperatures are 8-bit twos complement degrees
// RULE3 - config bit 3 picks diode or analog pair
// RULE4 - sixteen conversions averaged per channel result
// RULE5 - short conversions 711 us, remote 2.13 ms
// RULE6 - start bit 0 set, clear bit 2 low
// RULE7 - software sets bit 1 to enable interrupt
// RULE8 - pass runs remote one first, local last
// RULE9 - finished average stored without software help
// RULE10 - passes repeat until start bit cleared
// RULE11 - reads return latest result, never stall sequencer
// RULE12 - shared pair measured both ways every pass
// RULE13 - analog mode: 27h, 29h stored, temperature dropped
// RULE14 - diode mode: remote two at 29h only
// RULE15 - eighteen short plus two long channels per pass
// RULE16 - timing from 22.5 kHz tick divider
// RULE17 - fan speed loop lives outside this sequencer
// RULE18 - voltage alarms above high or below low
// RULE19 - temperature alarm sets hot, clears below hysteresis
// RULE20 - clear bit holds interrupt low, clears alarms
// RULE21 - limits checked per stored result, signed temperatures
`timescale 1ns/1ns
module tvms_top #(
    parameter int TICK_CYCLES_P = tvms_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    // apb slave
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [8:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    // shared converter
    output logic              conv_start_o,
    output logic [tvms_pkg::CH_W-1:0] conv_chan_o,
    input  wire logic [7:0]   conv_data_i,
    // pins and events
    output logic              pin_mode_analog_o,
    output logic              int_o
);
    import tvms_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_temp(input logic [CH_W-1:0] ch);
        return (ch == CH_REMOTE1) || (ch == CH_REMOTE2) || (ch == CH_LOCAL);
    endfunction

    function automatic logic is_limit(input logic [IDX_W-1:0] idx);
        return ((idx >= IDX_HIGH_BASE) && (idx <= IDX_HIGH_LAST))
            || ((idx >= IDX_LOW_BASE) && (idx <= IDX_LOW_LAST));
    endfunction

    function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
        logic hit;
        hit = 1'b0;
        if (idx == IDX_CFG || idx == IDX_BUSY || idx == IDX_ALARM) begin
            hit = 1'b1;
        end else if (idx == IDX_LOCAL) begin
            hit = 1'b1;
        end else if (idx >= IDX_RESULT_BASE && idx <= IDX_RESULT_LAST) begin
            hit = 1'b1;
        end else if (is_limit(idx)) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tvms_mem_if mem ();

    logic [7:0]          cfg_reg;
    logic [7:0]          data_meta_reg;
    logic [7:0]          data_sync_reg;
    logic [TICK_W-1:0]   tick_cnt_reg;
    logic                tick_reg;
    tvms_state_t         state_reg;
    logic [CH_W-1:0]     chan_reg;
    logic [3:0]          avg_cnt_reg;
    logic [CONV_W-1:0]   conv_cnt_reg;
    logic [SUM_W-1:0]    sum_reg;
    logic [7:0]          hi_lim_reg;
    logic [NUM_CH-1:0]   alarm_reg;
    logic                conv_start_reg;
    logic                int_reg;
    logic [31:0]         prdata_reg;
    logic                pready_reg;
    logic                pslverr_reg;

    logic [IDX_W-1:0]    apb_idx;
    logic                apb_acc;
    logic                apb_done_wr;
    logic                apb_lim_wr;
    logic                run;
    logic                analog_mode;
    logic                discard;
    logic                store_go;
    logic [7:0]          avg;
    logic [7:0]          lo_lim;
    logic                over;
    logic                under;
    logic [IDX_W-1:0]    result_idx;
    logic [SUM_W-1:0]    sample_ext;
    logic [CONV_W-1:0]   conv_last;

    tvms_value_mem u_mem (
        .core_clk_i (core_clk_i),
        .mem_port   (mem)
    );

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign apb_idx     = paddr_i[8:2];
    assign apb_acc     = psel_i & penable_i;
    assign apb_done_wr = apb_acc & pready_reg & pwrite_i & (paddr_i[1:0] == 2'b00);
    assign apb_lim_wr  = apb_done_wr & is_limit(apb_idx);

    // read address held from setup, so data is ready in the first access cycle
    assign mem.ra_addr = apb_idx;

    // fixed two-cycle access phase; reads never wait for the sequencer
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= apb_acc & ~pready_reg; // see RULE11
            pslverr_reg <= apb_acc & ~pready_reg
                           & ~(is_mapped(apb_idx) & (paddr_i[1:0] == 2'b00));
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_reg <= 32'h0000_0000;
        end else if (apb_acc & ~pready_reg) begin
            if (!is_mapped(apb_idx) || paddr_i[1:0] != 2'b00) begin
                prdata_reg <= 32'h0000_0000;
            end else if (apb_idx == IDX_CFG) begin
                prdata_reg <= {24'h00_0000, cfg_reg};
            end else if (apb_idx == IDX_BUSY) begin
                prdata_reg <= {24'h00_0000, (state_reg != S_IDLE), 2'b00, chan_reg};
            end else if (apb_idx == IDX_ALARM) begin
                prdata_reg <= {12'h000, alarm_reg};
            end else begin
                prdata_reg <= {24'h00_0000, mem.ra_data}; // see RULE11
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= CFG_RESET;
        end else if (apb_done_wr && apb_idx == IDX_CFG) begin
            cfg_reg <= pwdata_i[7:0]; // see RULE6 RULE7 RULE10 RULE3
        end
    end

    assign run         = cfg_reg[CFG_START_BIT] & ~cfg_reg[CFG_INTCLR_BIT]; // see RULE6
    assign analog_mode = cfg_reg[CFG_PINMODE_BIT]; // see RULE3

    // ------------------------------------------------------------
    // converter input and timebase
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_meta_reg <= 8'h00;
            data_sync_reg <= 8'h00;
        end else begin
            data_meta_reg <= conv_data_i;
            data_sync_reg <= data_meta_reg;
        end
    end

    // sequencer-only stand-in for the 22.5 kHz oscillator, see RULE17
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES_P - 1)) begin
            tick_cnt_reg <= '0; // see RULE16
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    assign conv_last  = (chan_reg == CH_REMOTE1 || chan_reg == CH_REMOTE2)
                        ? LONG_LAST : SHORT_LAST; // see RULE5 RULE15
    assign sample_ext = is_temp(chan_reg) ? {{4{data_sync_reg[7]}}, data_sync_reg}
                                          : {4'h0, data_sync_reg}; // see RULE2
    assign avg        = sum_reg[SUM_W-1:4]; // see RULE4

    // pair measured both ways; configuration only decides what is kept
    always_comb begin
        discard = 1'b0;
        if (chan_reg == CH_REMOTE2) begin
            discard = analog_mode; // see RULE13 RULE12
        end else if (chan_reg == CH_GENERAL_ANALOG_INPUT_EIGHT || chan_reg == CH_GENERAL_ANALOG_INPUT_NINE) begin
            discard = ~analog_mode; // see RULE14 RULE12
        end
    end

    always_comb begin
        if (chan_reg == CH_LOCAL) begin
            result_idx = IDX_LOCAL; // see RULE1
        end else if (chan_reg == CH_REMOTE2) begin
            result_idx = IDX_AIN_B; // see RULE14
        end else begin
            result_idx = IDX_RESULT_BASE + {2'b00, chan_reg};
        end
    end

    // apb limit writes take the port first; the store just waits a cycle
    assign store_go    = (state_reg == S_STORE) & ~apb_lim_wr & run;
    assign mem.rb_addr = (state_reg == S_LIM_HI) ? IDX_HIGH_BASE + {2'b00, chan_reg}
                                                 : IDX_LOW_BASE + {2'b00, chan_reg};
    assign mem.wr_en   = apb_lim_wr | (store_go & ~discard); // see RULE9
    assign mem.wr_addr = apb_lim_wr ? apb_idx : result_idx;
    assign mem.wr_data = apb_lim_wr ? pwdata_i[7:0] : avg;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg      <= S_IDLE;
            chan_reg       <= CH_REMOTE1;
            avg_cnt_reg    <= 4'h0;
            conv_cnt_reg   <= '0;
            sum_reg        <= '0;
            conv_start_reg <= 1'b0;
        end else if (!run) begin
            state_reg      <= S_IDLE; // see RULE10
            conv_start_reg <= 1'b0;
        end else begin
            conv_start_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    chan_reg    <= CH_REMOTE1; // see RULE8
                    avg_cnt_reg <= 4'h0;
                    sum_reg     <= '0;
                    state_reg   <= S_START;
                end
                S_START: begin
                    conv_start_reg <= 1'b1;
                    conv_cnt_reg   <= '0;
                    state_reg      <= S_CONV;
                end
                S_CONV: begin
                    if (tick_reg) begin
                        conv_cnt_reg <= conv_cnt_reg + 1'b1;
                        if (conv_cnt_reg == conv_last) begin
                            state_reg <= S_ACC; // see RULE5
                        end
                    end
                end
                S_ACC: begin
                    sum_reg     <= sum_reg + sample_ext;
                    avg_cnt_reg <= avg_cnt_reg + 1'b1;
                    if (avg_cnt_reg == AVG_LAST) begin
                        state_reg <= S_LIM_HI; // see RULE4
                    end else begin
                        state_reg <= S_START;
                    end
                end
                S_LIM_HI: begin
                    state_reg <= S_LIM_LO;
                end
                S_LIM_LO: begin
                    state_reg <= S_STORE;
                end
                S_STORE: begin
                    if (store_go) begin
                        avg_cnt_reg <= 4'h0;
                        sum_reg     <= '0;
                        state_reg   <= S_START;
                        if (chan_reg == CH_LOCAL) begin
                            chan_reg <= CH_REMOTE1; // see RULE8 RULE10
                        end else begin
                            chan_reg <= chan_reg + 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_lim_reg <= 8'h00;
        end else if (state_reg == S_LIM_LO) begin
            hi_lim_reg <= mem.rb_data;
        end
    end

    // ------------------------------------------------------------
    // limit checks
    // ------------------------------------------------------------
    assign lo_lim = mem.rb_data;

    always_comb begin
        if (is_temp(chan_reg)) begin
            over  = $signed(avg) > $signed(hi_lim_reg); // see RULE21 RULE19
            under = $signed(avg) < $signed(lo_lim);
        end else begin
            over  = avg > hi_lim_reg; // see RULE18
            under = avg < lo_lim;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_alarm
            logic upd;
            logic set;
            logic cool;
            assign upd  = store_go & ~discard & (chan_reg == CH_W'(gi)); // see RULE21
            assign set  = upd & (is_temp(CH_W'(gi)) ? over : (over | under)); // see RULE18
            assign cool = upd & is_temp(CH_W'(gi)) & under; // see RULE19

            // a new excursion wins over a clear in the same cycle
            always_ff @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    alarm_reg[gi] <= 1'b0;
                end else if (set) begin
                    alarm_reg[gi] <= 1'b1;
                end else if (cool || cfg_reg[CFG_INTCLR_BIT]) begin
                    alarm_reg[gi] <= 1'b0; // see RULE20 RULE19
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_reg <= 1'b0;
        end else begin
            int_reg <= cfg_reg[CFG_INTEN_BIT] & ~cfg_reg[CFG_INTCLR_BIT]
                       & (|alarm_reg); // see RULE20 RULE7
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic pin_mode_reg;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_mode_reg <= 1'b0;
        end else begin
            pin_mode_reg <= analog_mode; // see RULE3
        end
    end

    assign prdata_o          = prdata_reg;
    assign pready_o          = pready_reg;
    assign pslverr_o         = pslverr_reg;
    assign conv_start_o      = conv_start_reg;
    assign conv_chan_o       = chan_reg;
    assign pin_mode_analog_o = pin_mode_reg;
    assign int_o             = int_reg;
endmodule

//--- src/tvms_pkg.sv
// shared constants and types of the monitoring sequencer
package tvms_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int          IDX_W           = 7;
    localparam logic [6:0]  IDX_CFG         = 7'h00;
    localparam logic [6:0]  IDX_BUSY        = 7'h02;
    localparam logic [6:0]  IDX_ALARM       = 7'h03;
    localparam logic [6:0]  IDX_LOCAL       = 7'h1F;
    localparam logic [6:0]  IDX_AIN_A       = 7'h27;
    localparam logic [6:0]  IDX_AIN_B       = 7'h29;
    localparam logic [6:0]  IDX_RESULT_BASE = 7'h20;
    localparam logic [6:0]  IDX_RESULT_LAST = 7'h33;
    localparam logic [6:0]  IDX_HIGH_BASE   = 7'h40;
    localparam logic [6:0]  IDX_HIGH_LAST   = 7'h53;
    localparam logic [6:0]  IDX_LOW_BASE    = 7'h60;
    localparam logic [6:0]  IDX_LOW_LAST    = 7'h73;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    localparam int          CFG_START_BIT   = 0;
    localparam int          CFG_INTEN_BIT   = 1;
    localparam int          CFG_INTCLR_BIT  = 2;
    localparam int          CFG_PINMODE_BIT = 3;
    localparam logic [7:0]  CFG_RESET       = 8'h00;
    localparam int          BUSY_BIT        = 7;

    // ------------------------------------------------------------
    // channels in measurement order
    // ------------------------------------------------------------
    localparam int          NUM_CH          = 20;
    localparam int          CH_W            = 5;
    localparam logic [4:0]  CH_REMOTE1      = 5'h00;
    localparam logic [4:0]  CH_REMOTE2      = 5'h01;
    localparam logic [4:0]  CH_GENERAL_ANALOG_INPUT_EIGHT         = 5'h07;
    localparam logic [4:0]  CH_GENERAL_ANALOG_INPUT_NINE         = 5'h09;
    localparam logic [4:0]  CH_LOCAL        = 5'h13;

    // ------------------------------------------------------------
    // averaging and timing
    // ------------------------------------------------------------
    localparam int          SUM_W           = 12;
    localparam logic [3:0]  AVG_LAST        = 4'hF;
    localparam int          CLK_FREQ_HZ     = 20_000_000;
    localparam int          OSC_FREQ_HZ     = 22_500;
    localparam int          TICK_CYCLES     = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam int          TICK_W          = 10;
    localparam int          SHORT_CONV_US   = 711;
    localparam int          LONG_CONV_US    = 2130;
    localparam int          SHORT_TICKS     = (SHORT_CONV_US * OSC_FREQ_HZ + 999_999) / 1_000_000;
    localparam int          LONG_TICKS      = (LONG_CONV_US * OSC_FREQ_HZ + 999_999) / 1_000_000;
    localparam int          CONV_W          = 6;
    localparam logic [5:0]  SHORT_LAST      = 6'(SHORT_TICKS - 1);
    localparam logic [5:0]  LONG_LAST       = 6'(LONG_TICKS - 1);

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_START  = 3'b001,
        S_CONV   = 3'b010,
        S_ACC    = 3'b011,
        S_LIM_HI = 3'b100,
        S_LIM_LO = 3'b101,
        S_STORE  = 3'b110
    } tvms_state_t;

endpackage

//--- src/tvms_mem_if.sv
// value and limit memory port bundle
`timescale 1ns/1ns
interface tvms_mem_if;
    logic       wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] ra_addr;
    logic [7:0] ra_data;
    logic [6:0] rb_addr;
    logic [7:0] rb_data;

    modport mem_side  (input wr_en, wr_addr, wr_data, ra_addr, rb_addr,
                       output ra_data, rb_data);
    modport user_side (output wr_en, wr_addr, wr_data, ra_addr, rb_addr,
                       input ra_data, rb_data);
endinterface

//--- src/tvms_value_mem.sv
// register-indexed byte memory, one write port, two registered read ports
`timescale 1ns/1ns
module tvms_value_mem (
    // clock
    input  wire logic         core_clk_i,
    // ports
    tvms_mem_if.mem_side      mem_port
);
    import tvms_pkg::*;

    logic [7:0] store_mem [0:(2**IDX_W)-1];
    logic [7:0] ra_reg;
    logic [7:0] rb_reg;

    // no reset on the array: contents are undefined until written
    always_ff @(posedge core_clk_i) begin
        if (mem_port.wr_en) begin
            store_mem[mem_port.wr_addr] <= mem_port.wr_data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        ra_reg <= store_mem[mem_port.ra_addr];
        rb_reg <= store_mem[mem_port.rb_addr];
    end

    assign mem_port.ra_data = ra_reg;
    assign mem_port.rb_data = rb_reg;
endmodule

//--- dv/tvms_conv_model.sv
// converter model for the far side: per-channel samples around a fixed level
`timescale 1ns/1ns
module tvms_conv_model (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // converter
    input  wire logic       conv_start_i,
    input  wire logic [4:0] conv_chan_i,
    output logic      [7:0] conv_data_o
);
    logic       toggle_reg;
    logic [7:0] level;

    // samples alternate one count above and below, so only a true average hits level
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            toggle_reg <= 1'b0;
        end else if (conv_start_i) begin
            toggle_reg <= ~toggle_reg;
        end
    end

    // stable for the whole window: only changes when the channel steps or at a conversion start
    always_comb begin
        case (conv_chan_i)
            5'h01:   level = 8'hE7;
            5'h07:   level = 8'h5A;
            5'h09:   level = 8'hA5;
            5'h13:   level = 8'h19;
            default: level = 8'h80;
        endcase
        conv_data_o = toggle_reg ? level + 8'h01 : level - 8'h01;
    end
endmodule

//--- dv/tvms_chk.sv
// assertion checker on the ports of the monitoring sequencer top
`timescale 1ns/1ns
module tvms_chk (
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [8:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // converter and pins
    input wire logic        conv_start_o,
    input wire logic [4:0]  conv_chan_o,
    input wire logic        pin_mode_analog_o,
    input wire logic        int_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic cfg_wr;
    assign cfg_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 9'h000;

    chk_ready_second: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("pready missing in second access cycle");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    chk_err_unmapped: assert property (psel_i && penable_i && !pready_o && !pwrite_i
        && paddr_i == 9'h004 |=> pslverr_o && prdata_o == 32'h0000_0000)
        else $error("unmapped read not refused");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    chk_start_gap: assert property (conv_start_o |=> !conv_start_o [*8])
        else $error("conversion starts too close");
    chk_chan_order: assert property ($changed(conv_chan_o) && conv_chan_o != 5'h00
        |-> conv_chan_o == 5'($past(conv_chan_o) + 5'h01))
        else $error("channel order broken");
    chk_int_quiet: assert property (cfg_wr && (pwdata_i[2] || !pwdata_i[1])
        |-> ##2 !int_o [*4])
        else $error("interrupt active while disabled or cleared");
    chk_pin_mode: assert property (cfg_wr |-> ##2 pin_mode_analog_o == $past(pwdata_i[3], 2))
        else $error("pin mode does not follow config");
    chk_stop_idle: assert property (cfg_wr && !pwdata_i[0] |-> ##3 !conv_start_o [*8])
        else $error("conversion after stop");

    cov_int: cover property (int_o);
    cov_err: cover property (pslverr_o);
    cov_local: cover property (conv_start_o && conv_chan_o == 5'h13);
endmodule

bind tvms_top tvms_chk u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .pin_mode_analog_o(pin_mode_analog_o), .int_o(int_o)
);

//--- dv/tb.sv
// self-checking bench for the monitoring sequencer
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module tb;
    import tvms_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [8:0]  paddr = 9'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, conv_start, pin_mode, irq;
    logic [4:0]  conv_chan;
    logic [7:0]  conv_data;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          compares = 0;

    always #25 core_clk = ~core_clk;

    // short tick so a full pass stays near 25k cycles
    tvms_top #(.TICK_CYCLES_P(4)) u_tvms_top (
        .core_clk_i(core_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .conv_start_o(conv_start),
        .conv_chan_o(conv_chan), .conv_data_i(conv_data), .pin_mode_analog_o(pin_mode),
        .int_o(irq));
    tvms_conv_model u_tvms_conv_model (.core_clk_i(core_clk), .rst_i(rst),
        .conv_start_i(conv_start), .conv_chan_i(conv_chan), .conv_data_o(conv_data));

    // ------------------------------------------------------------
    // bus and wait helpers
    // ------------------------------------------------------------
    task automatic final_report();
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic logic [8:0] ba(input logic [6:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic apb(input logic w, input logic [6:0] idx, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ba(idx);
        pwdata <= {24'h00_0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_chan(input logic [4:0] ch);
        int n;
        n = 0;
        while (conv_chan !== ch && n < 40000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 40000) begin
            err_total++;
            final_report();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_map();
        logic [7:0] hi, lo;
        apb(1'b0, IDX_CFG, 8'h00);
        `CHK("cfg_rst", 32'h0000_0000, rd)
        apb(1'b0, 7'h01, 8'h00);
        `CHK("slverr", 1'b1, er)
        for (int ch = 0; ch < NUM_CH; ch++) begin
            hi = (ch == 2) ? 8'h10 : 8'hFF;
            lo = 8'h00;
            if (ch < 2 || ch == 19) begin
                hi = (ch == 19) ? 8'h10 : 8'h7F;
                lo = 8'h80;
            end
            apb(1'b1, IDX_HIGH_BASE + 7'(ch), hi);
            apb(1'b1, IDX_LOW_BASE + 7'(ch), lo);
        end
        apb(1'b0, IDX_HIGH_BASE + 7'h02, 8'h00);
        `CHK("limit_rw", 32'h0000_0010, rd)
    endtask

    task automatic t_diode();
        apb(1'b1, IDX_CFG, 8'h03);
        apb(1'b0, IDX_BUSY, 8'h00);
        `CHK("running", 1'b1, rd[7])
        wait_chan(CH_LOCAL);
        wait_chan(CH_REMOTE1);
        apb(1'b0, IDX_LOCAL, 8'h00);
        `CHK("local", 32'h0000_0019, rd)
        apb(1'b0, IDX_AIN_B, 8'h00);
        `CHK("remote2", 32'h0000_00E7, rd)
        apb(1'b0, IDX_RESULT_BASE, 8'h00);
        `CHK("remote1_signed", 32'h0000_0000, rd)
        `CHK("irq_alarm", 1'b1, irq)
        apb(1'b0, IDX_ALARM, 8'h00);
        `CHK("hot_set", 32'h0008_0004, rd)
    endtask

    task automatic t_analog();
        apb(1'b1, IDX_CFG, 8'h01);
        repeat (3) @(posedge core_clk);
        `CHK("irq_off", 1'b0, irq)
        apb(1'b1, IDX_CFG, 8'h0B);
        apb(1'b1, IDX_HIGH_BASE + 7'h13, 8'h7F);
        apb(1'b1, IDX_LOW_BASE + 7'h13, 8'h20);
        wait_chan(CH_LOCAL);
        wait_chan(CH_REMOTE1);
        `CHK("pin_mode", 1'b1, pin_mode)
        apb(1'b0, IDX_AIN_A, 8'h00);
        `CHK("general_analog_input_eight", 32'h0000_005A, rd)
        apb(1'b0, IDX_AIN_B, 8'h00);
        `CHK("general_analog_input_nine", 32'h0000_00A5, rd)
        `CHK("irq_on", 1'b1, irq)
        apb(1'b0, IDX_ALARM, 8'h00);
        `CHK("hot_clear", 32'h0000_0004, rd)
    endtask

    task automatic t_stop();
        apb(1'b1, IDX_CFG, 8'h0A);
        apb(1'b0, IDX_BUSY, 8'h00);
        `CHK("stopped", 1'b0, rd[7])
        apb(1'b1, IDX_CFG, 8'h06);
        repeat (3) @(posedge core_clk);
        `CHK("irq_clr", 1'b0, irq)
        apb(1'b0, IDX_ALARM, 8'h00);
        `CHK("alarm_clr", 32'h0000_0000, rd)
        apb(1'b0, IDX_CFG, 8'h00);
        `CHK("cfg_rw", 32'h0000_0006, rd)
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_map();
        t_diode();
        t_analog();
        t_stop();
        final_report();
    end
endmodule
